// file: hw/ebt_timer.sv
// ebt_timer: 8-bit interval / pwm / carrier timer with wishbone registers
// Functional notes
// - count clock is system clock divided 1,4,16,64,4096 or oscillator/128
// - idle or inactive output sits at the idle-level bit
// - pin driven only with output enable; interval mode gives 50% square wave
// - remote output in running carrier mode: 00 low, 01 high, 10 low, 11 carrier pulse; low in other modes or when stopped
// - bit 0 of carrier control is the read-only active gate flag
// - interval period match raises interrupt and clears counter
// - interval mode ignores the duty compare entirely
// - interval interrupt repeats every N+1 count clocks until stopped
// - counting begins within one count clock of run being set
// - interval match clears counter, toggles output, pulses interrupt
// - clearing run idles interrupt and output and clears the counter
// - pwm period match clears counter, interrupts, output active, compare duty
// - pwm duty match makes output inactive, compares period, no clear or interrupt
// - pwm period N+1 and active width M+1 count clocks
// - while running, new duty takes effect at the first old-duty match more than three count clocks after the write
// - pwm start masks first count clock, output inactive until first period match
`timescale 1ns/1ps
module ebt_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic osc_i,
    input wire logic envelope_irq_i,
    output logic timer_output_o,
    output logic timer_output_oe_o,
    output logic remote_output_o,
    output logic timer_interrupt_o
);
    typedef enum logic [1:0] {EBT_IDLE, EBT_PERIOD, EBT_DUTY} ebt_phase_e;

    logic [7:0] mode_reg;
    logic [7:0] period_reg;
    logic [7:0] duty_buf_reg;
    logic [7:0] duty_reg;
    logic duty_pend_reg;
    logic [1:0] duty_age_reg;
    logic [2:0] carrier_reg;
    logic [7:0] pin_dir_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic level_reg;
    logic level_next;
    logic irq_reg;
    logic irq_next;
    logic mask_reg;
    logic env_s1_reg;
    logic env_s2_reg;
    logic env_d_reg;
    logic [1:0] xfer_reg;
    ebt_phase_e phase_reg;
    ebt_phase_e phase_next;

    logic tick;
    logic run;
    logic [1:0] op;
    logic is_int;
    logic is_pwm;
    logic is_car;
    logic hit_period;
    logic hit_duty;
    logic wr_mode;
    logic wr_period;
    logic wr_duty;
    logic wr_carrier;
    logic wr_pin_dir;
    logic env_rise;
    logic remote_level;
    logic [7:0] rd_data;

    assign run = mode_reg[ebt_pkg::MODE_RUN];
    assign op = mode_reg[ebt_pkg::MODE_OP_LO +: 2];
    assign is_int = (op == ebt_pkg::OP_INTERVAL);
    assign is_pwm = (op == ebt_pkg::OP_PWM);
    assign is_car = (op == ebt_pkg::OP_CARRIER);

    ebt_prescaler u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .sel_i(mode_reg[ebt_pkg::MODE_CKS_LO +: 3]),
        .osc_i(osc_i),
        .tick_o(tick)
    );

    ebt_wb_regs u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel0_i(sel_i[0]),
        .ack_o(ack_o),
        .wr_mode_o(wr_mode),
        .wr_period_o(wr_period),
        .wr_duty_o(wr_duty),
        .wr_carrier_o(wr_carrier),
        .wr_pin_dir_o(wr_pin_dir)
    );

    // interval ignores the duty register; carrier alternates both with clears
    assign hit_period = (phase_reg == EBT_PERIOD) && (count_reg == period_reg);
    assign hit_duty = (phase_reg == EBT_DUTY) && !is_int && (count_reg == duty_reg);

    always_comb begin
        count_next = count_reg;
        level_next = level_reg;
        irq_next = 1'b0;
        phase_next = phase_reg;
        if (!run) begin
            count_next = 8'h00;
            level_next = 1'b0;
            phase_next = EBT_IDLE;
        end else if (tick) begin
            case (phase_reg)
                EBT_IDLE: begin
                    // first count clock only arms the counter
                    phase_next = EBT_PERIOD;
                end
                EBT_PERIOD: begin
                    if (hit_period) begin
                        count_next = 8'h00;
                        irq_next = 1'b1;
                        if (is_int) begin
                            level_next = ~level_reg;
                        end else begin
                            level_next = 1'b1;
                            phase_next = EBT_DUTY;
                        end
                    end else begin
                        count_next = count_reg + 8'h01;
                    end
                end
                EBT_DUTY: begin
                    if (hit_duty && is_pwm) begin
                        count_next = count_reg + 8'h01;
                        level_next = 1'b0;
                        phase_next = EBT_PERIOD;
                    end else if (hit_duty) begin
                        count_next = 8'h00;
                        irq_next = 1'b1;
                        level_next = 1'b0;
                        phase_next = EBT_PERIOD;
                    end else begin
                        count_next = count_reg + 8'h01;
                    end
                end
                default: begin
                    phase_next = EBT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 8'h00;
            level_reg <= 1'b0;
            irq_reg <= 1'b0;
            phase_reg <= EBT_IDLE;
        end else begin
            count_reg <= count_next;
            level_reg <= level_next;
            irq_reg <= irq_next;
            phase_reg <= phase_next;
        end
    end

    // duty write is latched; transfer at an old-duty match once three ticks have passed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_buf_reg <= ebt_pkg::RST_CMP;
            duty_reg <= ebt_pkg::RST_CMP;
            duty_pend_reg <= 1'b0;
            duty_age_reg <= 2'h0;
        end else if (wr_duty) begin
            duty_buf_reg <= dat_i[7:0];
            duty_pend_reg <= 1'b1;
            duty_age_reg <= 2'h0;
            if (!run) begin
                duty_reg <= dat_i[7:0];
                duty_pend_reg <= 1'b0;
            end
        end else if (duty_pend_reg && tick) begin
            if (hit_duty && duty_age_reg == ebt_pkg::DUTY_SETTLE) begin
                duty_reg <= duty_buf_reg;
                duty_pend_reg <= 1'b0;
            end else if (duty_age_reg != ebt_pkg::DUTY_SETTLE) begin
                duty_age_reg <= duty_age_reg + 2'h1;
            end
        end
    end

    // software side registers; mode change is only legal with run low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= ebt_pkg::RST_MODE;
            period_reg <= ebt_pkg::RST_CMP;
            pin_dir_reg <= ebt_pkg::RST_PIN_DIR;
        end else begin
            if (wr_mode) begin
                mode_reg <= dat_i[7:0];
            end
            if (wr_period) begin
                period_reg <= dat_i[7:0];
            end
            if (wr_pin_dir) begin
                pin_dir_reg <= dat_i[7:0];
            end
        end
    end

    // envelope request sync, then gate copy at the second count clock
    assign env_rise = env_s2_reg & ~env_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            env_s1_reg <= 1'b0;
            env_s2_reg <= 1'b0;
            env_d_reg <= 1'b0;
            xfer_reg <= 2'h0;
            carrier_reg <= ebt_pkg::RST_CARRIER[2:0];
        end else begin
            env_s1_reg <= envelope_irq_i;
            env_s2_reg <= env_s1_reg;
            env_d_reg <= env_s2_reg;
            if (env_rise) begin
                xfer_reg <= 2'h1;
            end else if (tick && xfer_reg != 2'h0) begin
                xfer_reg <= (xfer_reg == 2'h2) ? 2'h0 : 2'h2;
            end
            if (wr_carrier) begin
                carrier_reg[ebt_pkg::CAR_PENDING] <= dat_i[ebt_pkg::CAR_PENDING];
                carrier_reg[ebt_pkg::CAR_REMOTE] <= dat_i[ebt_pkg::CAR_REMOTE];
            end
            if (tick && xfer_reg == 2'h2) begin
                // active flag is read-only: only the transfer writes it
                carrier_reg[ebt_pkg::CAR_ACTIVE] <= carrier_reg[ebt_pkg::CAR_PENDING];
            end
        end
    end

    always_comb begin
        case ({carrier_reg[ebt_pkg::CAR_REMOTE], carrier_reg[ebt_pkg::CAR_PENDING]})
            2'b00: remote_level = 1'b0;
            2'b01: remote_level = 1'b1;
            2'b10: remote_level = 1'b0;
            default: remote_level = carrier_reg[ebt_pkg::CAR_ACTIVE] & level_reg;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= 1'b0;
        end else begin
            mask_reg <= is_car & run;
        end
    end

    // pin: inactive level is the idle-level bit, active is its inverse
    assign timer_output_o = level_reg ^ mode_reg[ebt_pkg::MODE_IDLE_LVL];
    assign timer_output_oe_o = mode_reg[ebt_pkg::MODE_OUT_EN];
    assign remote_output_o = mask_reg ? remote_level : 1'b0;
    assign timer_interrupt_o = irq_reg;

    always_comb begin
        case (adr_i)
            ebt_pkg::ADDR_MODE: rd_data = mode_reg;
            ebt_pkg::ADDR_PERIOD: rd_data = period_reg;
            ebt_pkg::ADDR_DUTY: rd_data = duty_buf_reg;
            ebt_pkg::ADDR_CARRIER: rd_data = {5'h00, carrier_reg};
            ebt_pkg::ADDR_PIN_DIR: rd_data = pin_dir_reg;
            ebt_pkg::ADDR_COUNT: rd_data = count_reg;
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= {24'h00_0000, rd_data};
        end
    end

    property p_stop_clears;
        @(posedge clk_i) disable iff (rst_i)
        !run |=> (count_reg == 8'h00) && !timer_interrupt_o && !level_reg;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop left counter or output");

    property p_int_match;
        @(posedge clk_i) disable iff (rst_i)
        run && tick && is_int && hit_period |=> timer_interrupt_o && count_reg == 8'h00
            && level_reg != $past(level_reg);
    endproperty
    a_int_match: assert property (p_int_match) else $error("interval match effect missing");

    property p_no_irq_without_match;
        @(posedge clk_i) disable iff (rst_i)
        !(tick && (hit_period || hit_duty)) |=> !timer_interrupt_o;
    endproperty
    a_no_irq_without_match: assert property (p_no_irq_without_match) else $error("spurious irq");

    property p_pwm_duty;
        @(posedge clk_i) disable iff (rst_i)
        run && tick && is_pwm && hit_duty |=> !level_reg && !timer_interrupt_o
            && phase_reg == EBT_PERIOD;
    endproperty
    a_pwm_duty: assert property (p_pwm_duty) else $error("pwm duty match wrong");

    property p_pwm_period;
        @(posedge clk_i) disable iff (rst_i)
        run && tick && is_pwm && hit_period |=> level_reg && phase_reg == EBT_DUTY;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("pwm period match wrong");

    property p_start_mask;
        @(posedge clk_i) disable iff (rst_i)
        phase_reg == EBT_IDLE && run && tick |=> count_reg == 8'h00 && !level_reg;
    endproperty
    a_start_mask: assert property (p_start_mask) else $error("first count clock not masked");

    property p_int_ignores_duty;
        @(posedge clk_i) disable iff (rst_i)
        run && tick && is_int && count_reg == duty_reg && count_reg != period_reg
            |=> !timer_interrupt_o && level_reg == $past(level_reg);
    endproperty
    a_int_ignores_duty: assert property (p_int_ignores_duty) else $error("duty seen in interval");

    property p_remote_low;
        @(posedge clk_i) disable iff (rst_i)
        !carrier_reg[ebt_pkg::CAR_PENDING] |-> !remote_output_o;
    endproperty
    a_remote_low: assert property (p_remote_low) else $error("remote output not low");

    property p_idle_level;
        @(posedge clk_i) disable iff (rst_i)
        !run ##1 !run |-> timer_output_o == mode_reg[ebt_pkg::MODE_IDLE_LVL];
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
endmodule : ebt_timer

// file: hw/ebt_pkg.sv
// ebt_pkg: register map, field positions, reset values and timing constants of the timer
package ebt_pkg;
    // word byte addresses on the wishbone slave
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_DUTY = 8'h08;
    localparam logic [7:0] ADDR_CARRIER = 8'h0c;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    // printed offsets of the documented registers, kept for reference
    localparam logic [15:0] OFS_PIN_DIR = 16'hff21;
    localparam logic [15:0] OFS_CARRIER = 16'hff6d;
    // mode register fields
    localparam int MODE_OUT_EN = 0;
    localparam int MODE_IDLE_LVL = 1;
    localparam int MODE_OP_LO = 2;
    localparam int MODE_CKS_LO = 4;
    localparam int MODE_RUN = 7;
    // carrier control fields
    localparam int CAR_ACTIVE = 0;
    localparam int CAR_PENDING = 1;
    localparam int CAR_REMOTE = 2;
    // pin direction fields
    localparam int PIN5_DIR = 5;
    localparam int PIN6_DIR = 6;
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [7:0] RST_CARRIER = 8'h00;
    localparam logic [7:0] RST_PIN_DIR = 8'hff;
    // clock select codes
    localparam logic [2:0] CKS_DIV1 = 3'h0;
    localparam logic [2:0] CKS_DIV4 = 3'h1;
    localparam logic [2:0] CKS_DIV16 = 3'h2;
    localparam logic [2:0] CKS_DIV64 = 3'h3;
    localparam logic [2:0] CKS_DIV4096 = 3'h4;
    localparam logic [2:0] CKS_OSC128 = 3'h5;
    localparam int PRE_WIDTH = 12;
    localparam int OSC_DIV_WIDTH = 7;
    // operating modes
    localparam logic [1:0] OP_INTERVAL = 2'h0;
    localparam logic [1:0] OP_CARRIER = 2'h1;
    localparam logic [1:0] OP_PWM = 2'h2;
    // count clocks a duty write needs before it may be transferred
    localparam logic [1:0] DUTY_SETTLE = 2'h3;
endpackage : ebt_pkg

// file: hw/ebt_prescaler.sv
// ebt_prescaler: count-clock enable pulse from the system or oscillator clock
`timescale 1ns/1ps
module ebt_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    input wire logic osc_i,
    output logic tick_o
);
    logic [ebt_pkg::PRE_WIDTH-1:0] div_reg;
    logic [ebt_pkg::OSC_DIV_WIDTH-1:0] osc_div_reg;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_d_reg;
    logic osc_rise;
    logic [ebt_pkg::PRE_WIDTH-1:0] div_all;
    logic osc_tick;

    // oscillator enters through two flops; only the second one is looked at
    assign osc_rise = osc_s2_reg & ~osc_d_reg;
    assign osc_tick = osc_rise && (osc_div_reg == '1);
    // terminal count for each ratio: all low bits set
    assign div_all = div_reg + 12'h001;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            div_reg <= '0;
            osc_div_reg <= '0;
        end else begin
            div_reg <= div_all;
            if (osc_rise) begin
                osc_div_reg <= osc_div_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_d_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_i;
            osc_s2_reg <= osc_s1_reg;
            osc_d_reg <= osc_s2_reg;
        end
    end

    // prohibited codes give no tick, so the timer simply holds
    always_comb begin
        case (sel_i)
            ebt_pkg::CKS_DIV1: tick_o = run_i;
            ebt_pkg::CKS_DIV4: tick_o = run_i && (div_reg[1:0] == 2'h3);
            ebt_pkg::CKS_DIV16: tick_o = run_i && (div_reg[3:0] == 4'hf);
            ebt_pkg::CKS_DIV64: tick_o = run_i && (div_reg[5:0] == 6'h3f);
            ebt_pkg::CKS_DIV4096: tick_o = run_i && (div_reg == 12'hfff);
            ebt_pkg::CKS_OSC128: tick_o = run_i && osc_tick;
            default: tick_o = 1'b0;
        endcase
    end
endmodule : ebt_prescaler

// file: hw/ebt_wb_regs.sv
// ebt_wb_regs: classic wishbone slave handshake and address decode
`timescale 1ns/1ps
module ebt_wb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic sel0_i,
    output logic ack_o,
    output logic wr_mode_o,
    output logic wr_period_o,
    output logic wr_duty_o,
    output logic wr_carrier_o,
    output logic wr_pin_dir_o
);
    logic ack_reg;
    logic req;
    logic wr;

    // one wait state, ack for exactly one cycle, unmapped reads return zero
    assign req = cyc_i && stb_i && !ack_reg;
    // write lands on the ack edge, where the master still holds address and data
    assign wr = cyc_i && stb_i && ack_reg && we_i && sel0_i;
    assign ack_o = ack_reg;
    assign wr_mode_o = wr && (adr_i == ebt_pkg::ADDR_MODE);
    assign wr_period_o = wr && (adr_i == ebt_pkg::ADDR_PERIOD);
    assign wr_duty_o = wr && (adr_i == ebt_pkg::ADDR_DUTY);
    assign wr_carrier_o = wr && (adr_i == ebt_pkg::ADDR_CARRIER);
    assign wr_pin_dir_o = wr && (adr_i == ebt_pkg::ADDR_PIN_DIR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end
endmodule : ebt_wb_regs

// file: verif/ebt_env_model.sv
// ebt_env_model: envelope timer and internal oscillator standing beside the timer
`timescale 1ns/1ps
module ebt_env_model #(
    parameter int ENV_PERIOD = 200
) (
    input wire logic clk_i,
    output logic envelope_irq_o,
    output logic osc_o
);
    int cnt = 0;
    // oscillator runs free and unrelated to clk_i: 10 ns period
    initial osc_o = 1'b0;
    always #5 osc_o = ~osc_o;
    // envelope period kept far above six count clocks of the timer
    always @(posedge clk_i) begin
        cnt <= (cnt == ENV_PERIOD - 1) ? 0 : cnt + 1;
        envelope_irq_o <= (cnt < 2);
    end
endmodule : ebt_env_model

// file: verif/tb.sv
// tb: self-checking bench for the interval, pwm and carrier timer
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, osc_i, envelope_irq_i, timer_output_o, timer_output_oe_o;
    logic remote_output_o, timer_interrupt_o;
    logic [7:0] q;
    logic [7:0] cur = 8'h00;
    int bad_count = 0;
    int num_checks = 0;
    int per, act, a2, n, m, h, e;
    int divs[5] = '{4, 16, 64, 4096, 320};
    always #2 clk_i = ~clk_i;
    ebt_timer u_ebt_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .osc_i(osc_i), .envelope_irq_i(envelope_irq_i),
        .timer_output_o(timer_output_o), .timer_output_oe_o(timer_output_oe_o),
        .remote_output_o(remote_output_o), .timer_interrupt_o(timer_interrupt_o));
    ebt_env_model u_ebt_env_model (.clk_i(clk_i), .envelope_irq_o(envelope_irq_i),
        .osc_o(osc_i));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // one classic cycle; ack is read at the edge before the design updates it
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) chk("ack", 32'h1, 32'h0);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    function automatic logic [7:0] mv(input logic run, input logic [2:0] cks,
        input logic [1:0] op, input logic idle);
        logic [7:0] v;
        v = 8'h00;
        v[ebt_pkg::MODE_RUN] = run;
        v[ebt_pkg::MODE_CKS_LO +: 3] = cks;
        v[ebt_pkg::MODE_OP_LO +: 2] = op;
        v[ebt_pkg::MODE_IDLE_LVL] = idle;
        v[ebt_pkg::MODE_OUT_EN] = 1'b1;
        return v;
    endfunction : mv
    // stop with settings unchanged, reload compares, configure, then flip only run
    task automatic start(input logic [2:0] cks, input logic [1:0] op, input logic idle,
        input logic [7:0] pv, input logic [7:0] dv);
        cur[ebt_pkg::MODE_RUN] = 1'b0;
        wb(ebt_pkg::ADDR_MODE, 1'b1, cur);
        wb(ebt_pkg::ADDR_PERIOD, 1'b1, pv);
        wb(ebt_pkg::ADDR_DUTY, 1'b1, dv);
        wb(ebt_pkg::ADDR_MODE, 1'b1, mv(1'b0, cks, op, idle));
        cur = mv(1'b1, cks, op, idle);
        wb(ebt_pkg::ADDR_MODE, 1'b1, cur);
    endtask : start
    // cycles up to the next interrupt, and how many of them the output was active
    task automatic meas(input logic idle, output int p, output int a);
        p = 0;
        a = 0;
        do begin
            @(posedge clk_i);
            p++;
            if (timer_output_o !== idle) a++;
        end while (timer_interrupt_o !== 1'b1 && p < 20000);
        if (p >= 20000) chk("irq timeout", 32'h0, 32'h1);
    endtask : meas
    task automatic quiet(input int cycles);
        int k;
        k = 0;
        repeat (cycles) begin
            @(posedge clk_i);
            if (timer_interrupt_o !== 1'b0) k++;
        end
        chk("stray irq", 32'h0, k);
    endtask : quiet
    initial begin
        repeat (90000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
    initial begin
        n = $urandom(32'hb1521097);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(ebt_pkg::ADDR_MODE, 1'b0, 8'h00);
        chk("mode reset", ebt_pkg::RST_MODE, q);
        wb(ebt_pkg::ADDR_DUTY, 1'b0, 8'h00);
        chk("duty reset", ebt_pkg::RST_CMP, q);
        wb(ebt_pkg::ADDR_CARRIER, 1'b0, 8'h00);
        chk("carrier reset", ebt_pkg::RST_CARRIER, q);
        wb(ebt_pkg::ADDR_PIN_DIR, 1'b0, 8'h00);
        chk("pin dir reset", ebt_pkg::RST_PIN_DIR, q);
        wb(ebt_pkg::ADDR_PIN_DIR, 1'b1, 8'h00);
        wb(8'h3c, 1'b1, 8'h5a);
        wb(8'h3c, 1'b0, 8'h00);
        chk("unmapped", 32'h0, q);
        // interval with idle high; duty 0 would match every period if it were used
        n = 1 + $urandom % 6;
        start(ebt_pkg::CKS_DIV1, ebt_pkg::OP_INTERVAL, 1'b1, n[7:0], 8'h00);
        meas(1'b1, per, act);
        chk("start delay", 32'h1, per <= n + 4);
        chk("oe", 32'h1, timer_output_oe_o);
        meas(1'b1, per, act);
        chk("interval", n + 1, per);
        meas(1'b1, per, a2);
        chk("interval again", n + 1, per);
        chk("square active", n + 1, act + a2);
        cur[ebt_pkg::MODE_RUN] = 1'b0;
        wb(ebt_pkg::ADDR_MODE, 1'b1, cur);
        wb(ebt_pkg::ADDR_COUNT, 1'b0, 8'h00);
        chk("count cleared", 32'h0, q);
        chk("idle level", 32'h1, timer_output_o);
        quiet(60);
        // slower count clocks; the oscillator gives 128 x 10 ns per tick
        for (int c = 1; c <= 5; c++) begin
            start(c[2:0], ebt_pkg::OP_INTERVAL, 1'b0, 8'h01, 8'h00);
            meas(1'b0, per, act);
            meas(1'b0, per, act);
            e = 2 * divs[c - 1];
            h = (c == 5);
            chk("clock select", 32'h1, per >= e - h && per <= e + h);
        end
        for (int c = 6; c <= 7; c++) begin
            start(c[2:0], ebt_pkg::OP_INTERVAL, 1'b0, 8'h01, 8'h00);
            quiet(300);
        end
        // pwm with random period and duty, then a duty rewrite while counting
        n = 4 + $urandom % 8;
        m = $urandom % n;
        start(ebt_pkg::CKS_DIV1, ebt_pkg::OP_PWM, 1'b0, n[7:0], m[7:0]);
        meas(1'b0, per, act);
        // only the last sample, launched with the first irq, may show the active level
        chk("pwm masked start", 32'h1, act);
        meas(1'b0, per, act);
        chk("pwm period", n + 1, per);
        chk("pwm width", m + 1, act);
        m = (m == 0) ? n - 1 : 0;
        wb(ebt_pkg::ADDR_DUTY, 1'b1, m[7:0]);
        repeat (3) meas(1'b0, per, act);
        chk("pwm new width", m + 1, act);
        chk("pwm new period", n + 1, per);
        // carrier: gate flag is read-only and follows the pending bit at envelope edges
        start(ebt_pkg::CKS_DIV1, ebt_pkg::OP_CARRIER, 1'b0, 8'h02, 8'h03);
        wb(ebt_pkg::ADDR_CARRIER, 1'b1, 8'h01);
        wb(ebt_pkg::ADDR_CARRIER, 1'b0, 8'h00);
        chk("gate flag read only", 32'h0, q[0]);
        for (int g = 0; g < 4; g++) begin
            wb(ebt_pkg::ADDR_CARRIER, 1'b1, {5'h00, g[1], g[0], 1'b0});
            repeat (500) @(posedge clk_i);
            wb(ebt_pkg::ADDR_CARRIER, 1'b0, 8'h00);
            chk("gate flag", g[0], q[ebt_pkg::CAR_ACTIVE]);
            h = 0;
            repeat (64) begin
                @(posedge clk_i);
                if (remote_output_o === 1'b1) h++;
            end
            e = (g == 3) ? (h > 0 && h < 64) : (h == ((g == 1) ? 64 : 0));
            chk("remote output", 32'h1, e);
        end
        finish_test();
    end
endmodule : tb
